// [core/acc_pkg.sv]
// Shared constants and types for the converter calibration control block.
// Assumes a single 10 MHz master clock and a byte-wide special register port.
package acc_pkg;

    localparam logic [7:0] ACC_CAL_CTRL_ADDR = 8'hf5;
    localparam logic [7:0] ACC_CAL_CTRL_RESET = 8'h00;

    // Field positions of the calibration control register
    localparam int ACC_BIT_BUSY = 7;
    localparam int ACC_BIT_GAIN_CAL_DISABLE = 6;
    localparam int ACC_BIT_AVG_COUNT_SEL_HI = 5;
    localparam int ACC_BIT_AVG_COUNT_SEL_LO = 4;
    localparam int ACC_BIT_RESERVED_ZERO = 3;
    localparam int ACC_BIT_CAL_ENABLE_ONE = 2;
    localparam int ACC_BIT_CAL_TYPE = 1;
    localparam int ACC_BIT_CAL_START = 0;

    // Averaged readings per calibration
    localparam logic [5:0] ACC_AVG_00 = 6'h0f;
    localparam logic [5:0] ACC_AVG_10 = 6'h1f;
    localparam logic [5:0] ACC_AVG_11 = 6'h3f;

    // Conversion timing in converter clocks
    localparam logic [3:0] ACC_CONV_CLKS = 4'hf;
    localparam logic [3:0] ACC_SYNC_CLKS = 4'h1;
    localparam logic [3:0] ACC_SAR_BITS = 4'hc;

    // Master clock divide ratios by select code 00, 01, 10, 11
    localparam logic [4:0] ACC_DIV_00 = 5'h10;
    localparam logic [4:0] ACC_DIV_01 = 5'h02;
    localparam logic [4:0] ACC_DIV_10 = 5'h04;
    localparam logic [4:0] ACC_DIV_11 = 5'h08;

    localparam logic [11:0] ACC_FULL_SCALE = 12'hfff;

    // Input routing during conversions
    localparam logic [1:0] ACC_MUX_SIGNAL = 2'h0;
    localparam logic [1:0] ACC_MUX_ZERO = 2'h1;
    localparam logic [1:0] ACC_MUX_FULL = 2'h2;

    typedef enum logic [2:0] {
        ACC_IDLE = 3'b000,
        ACC_SYNC = 3'b001,
        ACC_ACQ = 3'b010,
        ACC_CONV = 3'b011,
        ACC_DONE = 3'b100
    } acc_phase_type;

    typedef struct packed {
        acc_phase_type phase;
        logic [3:0] ctr;
        logic [3:0] bitn;
        logic [11:0] sar;
        logic [17:0] sum;
        logic [5:0] ncal;
        logic [6:0] ctl;
        logic busy;
        logic cal;
        logic [11:0] result;
        logic res_valid;
        logic track;
        logic [1:0] mux;
        logic [11:0] offs;
        logic signed [12:0] gerr;
        logic [7:0] rdata;
    } acc_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } acc_sfr_type;

endpackage

// [core/acc_clkdiv.sv]
// Converter clock enable divided down from the master clock.
// Assumes the select is static while conversions run.
`timescale 1ns/1ps
module acc_clkdiv
    import acc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [1:0] i_div_sel,
    output logic o_tick
);
    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } acc_div_type;

    acc_div_type s;
    acc_div_type next_s;
    logic [4:0] ratio;

    always_comb begin
        case (i_div_sel)
            2'h0: ratio = ACC_DIV_00;
            2'h1: ratio = ACC_DIV_01;
            2'h2: ratio = ACC_DIV_10;
            default: ratio = ACC_DIV_11;
        endcase
        next_s = s;
        next_s.tick = 1'b0;
        // Compare with >= so a smaller ratio picked mid-count cannot overrun
        if (s.cnt >= ratio - 5'h01) begin
            next_s.cnt = 5'h00;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 5'h01;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_tick = s.tick;
endmodule

// [core/acc_top.sv]
// Calibration control and busy logic of a 12-bit successive approximation converter.
// Assumes an analog comparator on i_cmp and a byte-wide special register port.
//
// Overview of operation
// - Busy reads high throughout every conversion or calibration cycle.
// - Busy clears by hardware when the running cycle completes.
// - Gain calibration runs when disable bit is 0, skipped when 1.
// - Averaged readings: code 00 gives 15, 10 gives 31, 11 gives 63.
// - Type bit 0 picks offset calibration, 1 picks gain calibration.
// - Setting the start bit launches the selected calibration cycle.
// - The start bit clears itself once calibration finishes.
// - Control register at F5H, resets to 00H, byte writes only.
// - Each conversion tracks, then holds while the search runs.
// - The offset- and gain-corrected final search value is latched as the result.
// - Conversion takes 15 clocks, plus 1 sync, plus 1 to 4 acquisition.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire acc_sfr_type i_sfr,
    input wire logic [1:0] i_div_sel,
    input wire logic [1:0] i_acq_sel,
    input wire logic i_conv_start,
    input wire logic i_cmp,
    output logic [7:0] o_sfr_rdata,
    output logic o_busy,
    output logic o_track,
    output logic [11:0] o_sar_dac,
    output logic [1:0] o_cal_mux,
    output logic [11:0] o_result,
    output logic o_result_valid,
    output logic [11:0] o_offset_coef,
    output logic signed [12:0] o_gain_coef
);
    acc_state_type s;
    acc_state_type next_s;
    logic tick;
    logic ctl_write;
    logic [5:0] avg_target;
    logic [11:0] raw;
    logic signed [13:0] diff;
    logic signed [26:0] prod;
    logic signed [14:0] fixed;
    logic [11:0] corrected;
    logic [11:0] diff_pos;
    logic [17:0] sum_next;
    logic [17:0] avg_full;

    acc_clkdiv u_div (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_div_sel(i_div_sel),
        .o_tick(tick)
    );

    // Code 01 is undefined; it falls back to the shortest average
    always_comb begin
        case (s.ctl[ACC_BIT_AVG_COUNT_SEL_HI:ACC_BIT_AVG_COUNT_SEL_LO])
            2'h2: avg_target = ACC_AVG_10;
            2'h3: avg_target = ACC_AVG_11;
            default: avg_target = ACC_AVG_00;
        endcase
    end

    // Final search value: last trial bit resolved in this clock
    always_comb begin
        raw = s.sar;
        if (!i_cmp) begin
            raw[0] = 1'b0;
        end
    end

    // Offset then gain correction; gain error is scaled by 1/4096
    always_comb begin
        diff = $signed({2'b00, raw}) - $signed({2'b00, s.offs});
        prod = diff * s.gerr;
        fixed = 15'(diff) - 15'(prod >>> 12);
        if (fixed < 0) begin
            corrected = 12'h000;
        end else if (fixed > $signed({3'b000, ACC_FULL_SCALE})) begin
            corrected = ACC_FULL_SCALE;
        end else begin
            corrected = fixed[11:0];
        end
        if (diff < 0) begin
            diff_pos = 12'h000;
        end else begin
            diff_pos = diff[11:0];
        end
    end

    // Offset readings average raw codes; gain readings average offset-free codes
    always_comb begin
        if (s.mux == ACC_MUX_FULL) begin
            sum_next = s.sum + {6'h00, diff_pos};
        end else begin
            sum_next = s.sum + {6'h00, raw};
        end
        case (avg_target)
            ACC_AVG_10: avg_full = sum_next / 18'(ACC_AVG_10);
            ACC_AVG_11: avg_full = sum_next / 18'(ACC_AVG_11);
            default: avg_full = sum_next / 18'(ACC_AVG_00);
        endcase
    end

    assign ctl_write = i_sfr.wr && (i_sfr.addr == ACC_CAL_CTRL_ADDR);

    always_comb begin
        next_s = s;
        next_s.res_valid = 1'b0;

        // Whole-byte write; busy bit is read-only and not stored
        if (ctl_write && !s.busy) begin
            next_s.ctl = i_sfr.wdata[6:0];
            if (i_sfr.wdata[ACC_BIT_CAL_START]) begin
                next_s.busy = 1'b1;
                next_s.cal = 1'b1;
                next_s.sum = 18'h00000;
                next_s.ncal = 6'h00;
                next_s.phase = ACC_SYNC;
                next_s.ctr = 4'h0;
                if (i_sfr.wdata[ACC_BIT_CAL_TYPE]) begin
                    next_s.mux = ACC_MUX_FULL;
                    if (i_sfr.wdata[ACC_BIT_GAIN_CAL_DISABLE]) begin
                        next_s.phase = ACC_DONE;
                    end
                end else begin
                    next_s.mux = ACC_MUX_ZERO;
                end
            end
        end else if (i_conv_start && !s.busy) begin
            next_s.busy = 1'b1;
            next_s.cal = 1'b0;
            next_s.mux = ACC_MUX_SIGNAL;
            next_s.phase = ACC_SYNC;
            next_s.ctr = 4'h0;
        end
        // A start arriving while busy falls through untouched

        if (tick) begin
            case (s.phase)
                ACC_IDLE: begin
                    next_s.track = 1'b0;
                end
                ACC_SYNC: begin
                    if (s.ctr == ACC_SYNC_CLKS - 4'h1) begin
                        next_s.phase = ACC_ACQ;
                        next_s.ctr = 4'h0;
                        next_s.track = 1'b1;
                    end else begin
                        next_s.ctr = s.ctr + 4'h1;
                    end
                end
                ACC_ACQ: begin
                    if (s.ctr == {2'b00, i_acq_sel}) begin
                        next_s.phase = ACC_CONV;
                        next_s.ctr = 4'h0;
                        next_s.track = 1'b0;
                        next_s.sar = 12'h800;
                        next_s.bitn = 4'hb;
                    end else begin
                        next_s.ctr = s.ctr + 4'h1;
                    end
                end
                ACC_CONV: begin
                    // Trials fill the first twelve clocks, the rest settle and latch
                    if (s.ctr < ACC_SAR_BITS) begin
                        if (!i_cmp) begin
                            next_s.sar[s.bitn] = 1'b0;
                        end
                        if (s.bitn != 4'h0) begin
                            next_s.sar[s.bitn - 4'h1] = 1'b1;
                            next_s.bitn = s.bitn - 4'h1;
                        end
                    end
                    if (s.ctr == ACC_CONV_CLKS - 4'h1) begin
                        next_s.ctr = 4'h0;
                        if (s.cal) begin
                            next_s.sum = sum_next;
                            next_s.ncal = s.ncal + 6'h01;
                            if (s.ncal + 6'h01 == avg_target) begin
                                next_s.phase = ACC_DONE;
                                if (s.mux == ACC_MUX_FULL) begin
                                    next_s.gerr = 13'($signed({1'b0, avg_full[11:0]})) -
                                        $signed({1'b0, ACC_FULL_SCALE});
                                end else begin
                                    next_s.offs = avg_full[11:0];
                                end
                            end else begin
                                next_s.phase = ACC_SYNC;
                            end
                        end else begin
                            next_s.result = corrected;
                            next_s.res_valid = 1'b1;
                            next_s.phase = ACC_DONE;
                        end
                    end else if (s.ctr < ACC_SAR_BITS) begin
                        next_s.ctr = s.ctr + 4'h1;
                        // Bit 0 trial is resolved by raw on the last search clock
                        if (s.ctr == ACC_SAR_BITS - 4'h1) begin
                            next_s.sar = raw;
                        end
                    end else begin
                        next_s.ctr = s.ctr + 4'h1;
                    end
                end
                ACC_DONE: begin
                    next_s.phase = ACC_IDLE;
                    next_s.busy = 1'b0;
                    next_s.mux = ACC_MUX_SIGNAL;
                    if (s.cal) begin
                        next_s.ctl[ACC_BIT_CAL_START] = 1'b0;
                        next_s.cal = 1'b0;
                    end
                end
                default: begin
                    next_s.phase = ACC_IDLE;
                    next_s.busy = 1'b0;
                end
            endcase
        end

        // Read data changes on the same clock as the register, one clock after the address
        if (i_sfr.addr == ACC_CAL_CTRL_ADDR) begin
            next_s.rdata = {next_s.busy, next_s.ctl};
        end else begin
            next_s.rdata = 8'h00;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            s <= '0;
            s.ctl <= ACC_CAL_CTRL_RESET[6:0];
        end else begin
            s <= next_s;
        end
    end

    assign o_sfr_rdata = s.rdata;
    assign o_busy = s.busy;
    assign o_track = s.track;
    assign o_sar_dac = s.sar;
    assign o_cal_mux = s.mux;
    assign o_result = s.result;
    assign o_result_valid = s.res_valid;
    assign o_offset_coef = s.offs;
    assign o_gain_coef = s.gerr;
endmodule

// [tb/acc_asserts.sv]
// Port checker for the calibration control block.
// Assumes binding onto acc_top, single master clock domain.
`timescale 1ns/1ps
module acc_asserts
    import acc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire acc_sfr_type i_sfr,
    input wire logic i_conv_start,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_busy,
    input wire logic o_track,
    input wire logic [11:0] o_result,
    input wire logic o_result_valid
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    logic sel;
    assign sel = i_sfr.addr == ACC_CAL_CTRL_ADDR;
    property p_reset_quiet;
        disable iff (1'b0) !i_resetn |=> o_sfr_rdata == 8'h00 && !o_busy;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");
    property p_rdata_other;
        !sel |=> o_sfr_rdata == 8'h00;
    endproperty
    a_rdata_other: assert property (p_rdata_other) else $error("read data on foreign address");
    property p_rdata_busy;
        sel |=> o_sfr_rdata[7] == o_busy;
    endproperty
    a_rdata_busy: assert property (p_rdata_busy) else $error("busy bit mismatch");
    property p_cal_start;
        sel && i_sfr.wr && i_sfr.wdata[0] && !o_busy |=> o_busy;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration did not start");
    // Shortest conversion is 17 ticks of two clocks, so eight busy cycles is safe
    property p_conv_span;
        i_conv_start && !o_busy && !(sel && i_sfr.wr) |=> o_busy [*8] ##[1:400] !o_busy;
    endproperty
    a_conv_span: assert property (p_conv_span) else $error("conversion busy span wrong");
    property p_track_busy;
        o_track |-> o_busy;
    endproperty
    a_track_busy: assert property (p_track_busy) else $error("track outside busy");
    property p_valid_pulse;
        o_result_valid |-> o_busy ##1 !o_result_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("result pulse wrong");
    property p_start_clear;
        $fell(o_busy) && sel && !i_sfr.wr |=> o_sfr_rdata[0] == 1'b0;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start bit not cleared");
    property p_result_change;
        $changed(o_result) |-> o_result_valid;
    endproperty
    a_result_change: assert property (p_result_change) else $error("result changed silently");
endmodule
bind acc_top acc_asserts i_chk(.i_mclk(i_mclk), .i_resetn(i_resetn), .i_sfr(i_sfr), .i_conv_start(i_conv_start),
    .o_sfr_rdata(o_sfr_rdata), .o_busy(o_busy), .o_track(o_track), .o_result(o_result),
    .o_result_valid(o_result_valid));

// [tb/acc_top_bench.sv]
// Self-checking bench for the calibration control block.
// Assumes converter clock at master clock divided by two.
`timescale 1ns/1ps
module acc_top_bench;
    import acc_pkg::*;
    typedef struct packed {
        logic [7:0] wd;
        logic cmp;
        logic [6:0] n;
        logic [1:0] mux;
        logic [11:0] off;
        logic [12:0] gain;
    } acc_row_type;
    // Calibration writes keep bit3 low, bit2 high
    acc_row_type rows [5] = '{'{8'h05, 1'b1, 7'h0f, 2'h1, 12'hfff, 13'h0000},
        '{8'h25, 1'b0, 7'h1f, 2'h1, 12'h000, 13'h0000}, '{8'h37, 1'b0, 7'h3f, 2'h2, 12'h000, 13'h1001},
        '{8'h47, 1'b1, 7'h00, 2'h0, 12'h000, 13'h1001}, '{8'h17, 1'b1, 7'h0f, 2'h2, 12'h000, 13'h0000}};
    logic i_mclk = 0, i_resetn = 0, i_conv_start = 0, i_cmp = 0;
    acc_sfr_type i_sfr = '0;
    logic [1:0] i_div_sel = 2'h1, i_acq_sel = 2'h0, o_cal_mux, mux;
    logic [7:0] o_sfr_rdata;
    logic o_busy, o_track, o_result_valid, prev;
    logic [11:0] o_result, o_offset_coef, o_sar_dac;
    logic signed [12:0] o_gain_coef;
    logic [6:0] n;
    int bad_count = 0, cmp_count = 0, k;
    always #50 i_mclk = ~i_mclk;
    acc_top i_dut(.i_mclk(i_mclk), .i_resetn(i_resetn), .i_sfr(i_sfr), .i_div_sel(i_div_sel),
        .i_acq_sel(i_acq_sel), .i_conv_start(i_conv_start), .i_cmp(i_cmp), .o_sfr_rdata(o_sfr_rdata),
        .o_busy(o_busy), .o_track(o_track), .o_sar_dac(o_sar_dac), .o_cal_mux(o_cal_mux), .o_result(o_result),
        .o_result_valid(o_result_valid), .o_offset_coef(o_offset_coef), .o_gain_coef(o_gain_coef));
    task chk(input logic [12:0] got, input logic [12:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_sfr <= '{addr: a, wr: 1'b1, wdata: d};
        @(posedge i_mclk);
        i_sfr <= '{addr: ACC_CAL_CTRL_ADDR, wr: 1'b0, wdata: 8'h00};
        #1;
    endtask
    task rd(input logic [7:0] exp);
        repeat (2) @(posedge i_mclk);
        #1 chk(13'(o_sfr_rdata), 13'(exp));
    endtask
    initial begin
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        i_sfr <= '{addr: ACC_CAL_CTRL_ADDR, wr: 1'b0, wdata: 8'h00};
        rd(8'h00);
        wr(8'h40, 8'h7e);
        // Bit 7 written high must be ignored; reserved bit 3 kept low
        wr(ACC_CAL_CTRL_ADDR, 8'h86);
        rd(8'h06);
        for (int r = 0; r < 5; r++) begin
            @(posedge i_mclk);
            i_cmp <= rows[r].cmp;
            wr(ACC_CAL_CTRL_ADDR, rows[r].wd);
            chk(13'(o_busy), 13'h1);
            n = 7'h00;
            mux = 2'h0;
            prev = 1'b0;
            k = 0;
            // First row also throws a write and a conversion at the busy block
            while (o_busy === 1'b1 && k < 8000) begin
                @(posedge i_mclk);
                i_sfr.wr <= (r == 0 && k == 3);
                i_conv_start <= (r == 0 && k == 3);
                i_sfr.wdata <= 8'h40;
                #1;
                if (o_track && !prev) begin
                    n++;
                    mux = o_cal_mux;
                end
                prev = o_track;
                k++;
            end
            chk(13'(k < 8000), 13'h1);
            chk(13'(n), 13'(rows[r].n));
            chk(13'(mux), 13'(rows[r].mux));
            rd(rows[r].wd & 8'h7e);
            chk(13'(o_offset_coef), 13'(rows[r].off));
            chk(o_gain_coef, rows[r].gain);
        end
        for (int c = 0; c < 2; c++) begin
            @(posedge i_mclk);
            i_cmp <= c[0];
            i_acq_sel <= 2'(c * 3);
            i_conv_start <= 1'b1;
            @(posedge i_mclk);
            i_conv_start <= 1'b0;
            k = 1;
            #1;
            while (o_result_valid !== 1'b1 && k < 500) begin
                @(posedge i_mclk);
                #1 k++;
            end
            chk(13'(o_result), c ? 13'h0fff : 13'h0000);
            chk(13'(o_sar_dac), c ? 13'h0fff : 13'h0000);
            // Tick phase alignment leaves a few clocks of slack
            chk(13'(k >= 33 + 6 * c && k <= 38 + 6 * c), 13'h1);
            repeat (4) @(posedge i_mclk);
            #1 chk(13'(o_busy), 13'h0);
        end
        report_and_stop;
    end
    initial begin
        #3000000;
        bad_count++;
        report_and_stop;
    end
endmodule
